// ---- src/ppt_defines.svh ----
// Constants for the preset position trigger block: field codes, digit layout, timing counts
`ifndef PPT_DEFINES_SVH
`define PPT_DEFINES_SVH

// Entries per output family (fast line-driver and photocoupler)
`define PPT_N_ENTRIES      32

// Host field codes on the setting port
`define PPT_FLD_TARGET     3'h0
`define PPT_FLD_FUNCTION   3'h1
`define PPT_FLD_TIME       3'h2
`define PPT_FLD_DISTANCE   3'h3
`define PPT_FLD_OFFSET     3'h4

// Lanes of the entry memory word
`define PPT_LANE_TARGET    2'h0
`define PPT_LANE_TIME      2'h1
`define PPT_LANE_DISTANCE  2'h2
`define PPT_LANE_OFFSET    2'h3
`define PPT_LANES          4

// Function word digit positions
`define PPT_DIG_AXIS_LSB   0
`define PPT_DIG_SEL_LSB    4
`define PPT_DIG_DIR_LSB    8

// Direction digit codes
`define PPT_DIR_FWD        4'h0
`define PPT_DIR_REV        4'h1
`define PPT_DIR_BOTH       4'h2

// Fast output selection codes
`define PPT_FSEL_OUT1      4'h1
`define PPT_FSEL_OUT2      4'h2
`define PPT_FSEL_OUT1_INV  4'h3
`define PPT_FSEL_OUT2_INV  4'h4

// Photocoupler output selection codes
`define PPT_PSEL_OUT1      4'h1
`define PPT_PSEL_OUT2      4'h2
`define PPT_PSEL_OUT3      4'h3
`define PPT_PSEL_OUT1_INV  4'h6
`define PPT_PSEL_OUT2_INV  4'h7
`define PPT_PSEL_OUT3_INV  4'h8

// Output counts and total width of the combined trigger vector
`define PPT_N_FAST         2
`define PPT_N_PHOTO        3
`define PPT_N_OUTS         5

// Timing: 25 MHz clock, microsecond and millisecond time bases
`define PPT_CLK_PERIOD_NS  40
`define PPT_US_NS          1000
`define PPT_US_CYCLES      (`PPT_US_NS / `PPT_CLK_PERIOD_NS)
`define PPT_MS_US          1000

// Reset value of the function word and the linear distance width limit
`define PPT_RESET_WORD     32'h0000_0000
`define PPT_SIGNED_MAX     32'h7fff_ffff

`endif

// ---- src/ppt_pkg.sv ----
// Types shared by the preset position trigger block
package ppt_pkg;

  typedef logic [31:0] ppt_word_t;

  // Decoded output selection of one entry
  typedef struct packed {
    logic       en;
    logic       inv;
    logic [2:0] out_idx;
  } ppt_out_map_s;

endpackage

// ---- src/ppt_entry_mem.sv ----
// Entry table memory: per-field write lanes, two registered read ports
`timescale 1ns/1ps
module ppt_entry_mem #(
  parameter int AW    = 6,
  parameter int LANES = 4,
  parameter int LW    = 32
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // Write port, one lane at a time
  input  wire logic                  wr_en,
  input  wire logic [1:0]            wr_lane,
  input  wire logic [AW-1:0]         wr_addr,
  input  wire logic [LW-1:0]         wr_data,
  // Scan read port
  input  wire logic [AW-1:0]         rd_a_addr,
  output logic      [LANES*LW-1:0]   rd_a_data,
  // Host read port
  input  wire logic [AW-1:0]         rd_b_addr,
  output logic      [LANES*LW-1:0]   rd_b_data
);

  localparam int DEPTH = 1 << AW;

  logic [LANES*LW-1:0] mem_reg [DEPTH];

  // Flops rather than RAM so every setting starts at zero after reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else if (wr_en) begin
      mem_reg[wr_addr][wr_lane*LW +: LW] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_a_data <= '0;
      rd_b_data <= '0;
    end else begin
      rd_a_data <= mem_reg[rd_a_addr];
      rd_b_data <= mem_reg[rd_b_addr];
    end
  end

endmodule

// ---- src/ppt_trigger.sv ----
// Preset position trigger table: crossing detection and pulse outputs
//
// Function
// (RULE_01) Signed 32-bit target, reset zero, immediate
// (RULE_02) Host writes axis digit zero, word limited
// (RULE_03) Fast digit 1: 1,2 true; 3,4 inverted
// (RULE_04) Photo digit 1: 1-3 true; 6-8 inverted
// (RULE_05) Direction digit: forward, reverse, or both
// (RULE_06) Host keeps digits three to seven zero
// (RULE_07) Output selection applies after setup command only
// (RULE_08) Direction change applies immediately
// (RULE_09) Time width: microseconds fast, milliseconds photo
// (RULE_10) Distance width: unsigned travel in reference units
// (RULE_11) Compensation offset added to target position
// (RULE_12) Global inversion also flips trigger outputs
// (RULE_13) Lowest entry index decides conflicting polarity
// (RULE_14) Host keeps distance width in permitted range
// (RULE_15) Out-of-range distance width raises combination alarm
// (RULE_16) Host changes settings only while stopped
// (RULE_17) Basis select: 0 time, 1 distance
// (RULE_18) Assert on first crossing, hold for width
`timescale 1ns/1ps
`include "ppt_defines.svh"
module ppt_trigger #(
  parameter int N_ENTRIES = `PPT_N_ENTRIES
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        resetn,
  // Drive position, sampled once per sweep of the entry table
  input  wire logic [31:0]                 position,
  // Setting table write
  input  wire logic                        wr_en,
  input  wire logic [$clog2(2*N_ENTRIES)-1:0] wr_entry,
  input  wire logic [2:0]                  wr_field,
  input  wire logic [31:0]                 wr_data,
  // Setting table read
  input  wire logic                        rd_en,
  input  wire logic [$clog2(2*N_ENTRIES)-1:0] rd_entry,
  input  wire logic [2:0]                  rd_field,
  output logic                             rd_valid,
  output logic      [31:0]                 rd_data,
  // Setup-device command
  input  wire logic                        config_cmd,
  // Drive configuration
  input  wire logic [`PPT_N_OUTS-1:0]      output_inversion_setting,
  input  wire logic                        width_basis_select,
  input  wire logic                        rotational_mode,
  input  wire logic [31:0]                 rotational_limit_first,
  input  wire logic [31:0]                 rotational_limit_second,
  // Trigger outputs and alarm
  output logic      [`PPT_N_FAST-1:0]      fast_out,
  output logic      [`PPT_N_PHOTO-1:0]     photo_out,
  output logic                             param_combo_alarm
);

  localparam int NE = 2 * N_ENTRIES;
  localparam int IW = $clog2(NE);
  localparam int LW = 32;

  // Decode an entry's active selection digit into enable, polarity and output
  function automatic ppt_pkg::ppt_out_map_s sel_map(input logic photo, input logic [3:0] sel);
    ppt_pkg::ppt_out_map_s m;
    m = '0;
    if (!photo) begin
      case (sel)
        `PPT_FSEL_OUT1:     m = '{en: 1'b1, inv: 1'b0, out_idx: 3'h0};
        `PPT_FSEL_OUT2:     m = '{en: 1'b1, inv: 1'b0, out_idx: 3'h1};
        `PPT_FSEL_OUT1_INV: m = '{en: 1'b1, inv: 1'b1, out_idx: 3'h0};
        `PPT_FSEL_OUT2_INV: m = '{en: 1'b1, inv: 1'b1, out_idx: 3'h1};
        default:            m = '0;
      endcase
    end else begin
      case (sel)
        `PPT_PSEL_OUT1:     m = '{en: 1'b1, inv: 1'b0, out_idx: 3'h2};
        `PPT_PSEL_OUT2:     m = '{en: 1'b1, inv: 1'b0, out_idx: 3'h3};
        `PPT_PSEL_OUT3:     m = '{en: 1'b1, inv: 1'b0, out_idx: 3'h4};
        `PPT_PSEL_OUT1_INV: m = '{en: 1'b1, inv: 1'b1, out_idx: 3'h2};
        `PPT_PSEL_OUT2_INV: m = '{en: 1'b1, inv: 1'b1, out_idx: 3'h3};
        `PPT_PSEL_OUT3_INV: m = '{en: 1'b1, inv: 1'b1, out_idx: 3'h4};
        default:            m = '0;
      endcase
    end
    return m;
  endfunction

  // Memory lane that holds a host field
  function automatic logic [1:0] field_lane(input logic [2:0] fld);
    case (fld)
      `PPT_FLD_TARGET:   return `PPT_LANE_TARGET;
      `PPT_FLD_TIME:     return `PPT_LANE_TIME;
      `PPT_FLD_DISTANCE: return `PPT_LANE_DISTANCE;
      default:           return `PPT_LANE_OFFSET;
    endcase
  endfunction

  // Per-entry state
  logic [31:0]     func_reg    [NE];
  logic [3:0]      eff_sel_reg [NE];
  logic [31:0]     stamp_reg   [NE];
  logic [NE-1:0]   active_reg;

  // Time bases
  logic [4:0]      us_div_reg;
  logic [9:0]      ms_div_reg;
  logic [31:0]     us_now_reg;
  logic [31:0]     ms_now_reg;

  // Scan state
  logic [IW-1:0]   scan_idx_reg;
  logic [IW-1:0]   proc_idx_reg;
  logic            proc_valid_reg;
  logic            primed_reg;
  logic [31:0]     cur_snap_reg;
  logic [31:0]     prev_snap_reg;

  // Host read pipeline
  logic            rd_stage_reg;
  logic [2:0]      rd_field_reg;
  logic [31:0]     rd_func_reg;

  logic [`PPT_LANES*LW-1:0] scan_word;
  logic [`PPT_LANES*LW-1:0] host_word;

  wire logic       mem_wr = wr_en && (wr_field != `PPT_FLD_FUNCTION);

  ppt_entry_mem #(
    .AW    (IW),
    .LANES (`PPT_LANES),
    .LW    (LW)
  ) u_mem (
    .clk       (clk),
    .resetn    (resetn),
    .wr_en     (mem_wr),
    .wr_lane   (field_lane(wr_field)),
    .wr_addr   (wr_entry),
    .wr_data   (wr_data),
    .rd_a_addr (scan_idx_reg),
    .rd_a_data (scan_word),
    .rd_b_addr (rd_entry),
    .rd_b_data (host_word)
  );

  // Fields of the entry under test
  wire logic [31:0] p_target = scan_word[`PPT_LANE_TARGET*LW +: LW];
  wire logic [31:0] p_time   = scan_word[`PPT_LANE_TIME*LW +: LW];
  wire logic [31:0] p_dist   = scan_word[`PPT_LANE_DISTANCE*LW +: LW];
  wire logic [31:0] p_offset = scan_word[`PPT_LANE_OFFSET*LW +: LW];
  wire logic        p_photo  = proc_idx_reg[IW-1];
  wire logic [3:0]  p_dir    = func_reg[proc_idx_reg][`PPT_DIG_DIR_LSB +: 4]; // RULE_08
  wire ppt_pkg::ppt_out_map_s p_map = sel_map(p_photo, eff_sel_reg[proc_idx_reg]); // RULE_03 RULE_04

  // Compensated trigger point, wraps like the position counter
  wire logic [31:0] p_point  = p_target + p_offset; // RULE_01 RULE_11

  wire logic fwd_cross = ($signed(prev_snap_reg) < $signed(p_point)) &&
                         ($signed(cur_snap_reg) >= $signed(p_point));
  wire logic rev_cross = ($signed(prev_snap_reg) > $signed(p_point)) &&
                         ($signed(cur_snap_reg) <= $signed(p_point));

  wire logic dir_hit = ((p_dir == `PPT_DIR_FWD)  && fwd_cross) ||
                       ((p_dir == `PPT_DIR_REV)  && rev_cross) ||
                       ((p_dir == `PPT_DIR_BOTH) && (fwd_cross || rev_cross)); // RULE_05

  wire logic p_fire  = proc_valid_reg && primed_reg && p_map.en && dir_hit; // RULE_18

  // Width measurement from the stamp taken at the crossing
  wire logic [31:0] p_now      = p_photo ? ms_now_reg : us_now_reg;
  wire logic [31:0] p_elapsed  = p_now - stamp_reg[proc_idx_reg];
  wire logic [31:0] p_travel_s = cur_snap_reg - stamp_reg[proc_idx_reg];
  wire logic [31:0] p_travel   = p_travel_s[31] ? (32'h0 - p_travel_s) : p_travel_s;
  wire logic p_expire = width_basis_select ? (p_travel >= p_dist)   // RULE_10 RULE_17
                                           : (p_elapsed >= p_time); // RULE_09 RULE_17

  // Distance width must fit the coordinate mode
  wire logic dist_in_rot = ($signed(p_dist) >= $signed(rotational_limit_first)) &&
                           ($signed(p_dist) <= $signed(rotational_limit_second));
  wire logic dist_bad    = rotational_mode ? !dist_in_rot : (p_dist > `PPT_SIGNED_MAX);
  wire logic p_alarm     = proc_valid_reg && width_basis_select && p_map.en && dist_bad; // RULE_15

  // Time bases: 1 us tick from the clock, 1 ms tick from the us tick
  wire logic us_tick = (us_div_reg == 5'(`PPT_US_CYCLES - 1));
  wire logic ms_tick = us_tick && (ms_div_reg == 10'(`PPT_MS_US - 1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      us_div_reg <= '0;
      ms_div_reg <= '0;
      us_now_reg <= '0;
      ms_now_reg <= '0;
    end else begin
      us_div_reg <= us_tick ? 5'h0 : us_div_reg + 5'h1;
      if (us_tick) begin
        ms_div_reg <= ms_tick ? 10'h0 : ms_div_reg + 10'h1;
        us_now_reg <= us_now_reg + 32'h1;
      end
      if (ms_tick) begin
        ms_now_reg <= ms_now_reg + 32'h1;
      end
    end
  end

  // Entries are visited one per clock; a sweep compares all entries against one
  // pair of position snapshots, trading 64 cycles of latency for a single comparator.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scan_idx_reg   <= '0;
      proc_idx_reg   <= '0;
      proc_valid_reg <= 1'b0;
      primed_reg     <= 1'b0;
      cur_snap_reg   <= '0;
      prev_snap_reg  <= '0;
    end else begin
      scan_idx_reg   <= scan_idx_reg + IW'(1);
      proc_idx_reg   <= scan_idx_reg;
      proc_valid_reg <= 1'b1;
      if (proc_valid_reg && (proc_idx_reg == IW'(NE - 1))) begin
        prev_snap_reg <= cur_snap_reg;
        cur_snap_reg  <= position;
        primed_reg    <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active_reg <= '0;
      for (int i = 0; i < NE; i++) begin
        stamp_reg[i] <= '0;
      end
    end else if (proc_valid_reg) begin
      if (p_fire) begin
        active_reg[proc_idx_reg] <= 1'b1; // RULE_18
        stamp_reg[proc_idx_reg]  <= width_basis_select ? p_point : p_now;
      end else if (!p_map.en || p_expire) begin
        active_reg[proc_idx_reg] <= 1'b0;
      end
    end
  end

  // Function words; output selection only moves to the active copy on setup
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NE; i++) begin
        func_reg[i]    <= `PPT_RESET_WORD;
        eff_sel_reg[i] <= '0;
      end
    end else begin
      if (wr_en && (wr_field == `PPT_FLD_FUNCTION)) begin
        func_reg[wr_entry] <= wr_data;
      end
      if (config_cmd) begin
        for (int i = 0; i < NE; i++) begin
          eff_sel_reg[i] <= func_reg[i][`PPT_DIG_SEL_LSB +: 4]; // RULE_07
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      param_combo_alarm <= 1'b0;
    end else if (p_alarm) begin
      param_combo_alarm <= 1'b1; // RULE_15
    end
  end

  // Combine entries onto outputs; first mapped entry fixes the polarity
  logic [`PPT_N_OUTS-1:0] lvl;
  logic [`PPT_N_OUTS-1:0] pol;
  logic [`PPT_N_OUTS-1:0] pol_set;
  ppt_pkg::ppt_out_map_s  cm;

  always_comb begin
    lvl     = '0;
    pol     = '0;
    pol_set = '0;
    cm      = '0;
    for (int e = 0; e < NE; e++) begin
      cm = sel_map(e >= N_ENTRIES, eff_sel_reg[e]);
      for (int o = 0; o < `PPT_N_OUTS; o++) begin
        if (cm.en && (cm.out_idx == 3'(o))) begin
          lvl[o] = lvl[o] | active_reg[e];
          if (!pol_set[o]) begin
            pol[o]     = cm.inv; // RULE_13
            pol_set[o] = 1'b1;
          end
        end
      end
    end
  end

  wire logic [`PPT_N_OUTS-1:0] out_next = lvl ^ pol ^ output_inversion_setting; // RULE_12

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fast_out  <= '0;
      photo_out <= '0;
    end else begin
      fast_out  <= out_next[`PPT_N_FAST-1:0];
      photo_out <= out_next[`PPT_N_OUTS-1:`PPT_N_FAST];
    end
  end

  // Host read: memory stage, then output register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_stage_reg <= 1'b0;
      rd_field_reg <= '0;
      rd_func_reg  <= '0;
      rd_valid     <= 1'b0;
      rd_data      <= '0;
    end else begin
      rd_stage_reg <= rd_en;
      rd_field_reg <= rd_field;
      rd_func_reg  <= func_reg[rd_entry];
      rd_valid     <= rd_stage_reg;
      if (rd_stage_reg) begin
        rd_data <= (rd_field_reg == `PPT_FLD_FUNCTION) ? rd_func_reg
                 : host_word[field_lane(rd_field_reg)*LW +: LW];
      end
    end
  end

endmodule

// ---- dv/ppt_trigger_assertions.sv ----
// Port assertions for the preset position trigger table
`timescale 1ns/1ps
module ppt_trigger_assertions (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Host side
  input wire logic        rd_en,
  input wire logic        rd_valid,
  input wire logic [31:0] rd_data,
  input wire logic        config_cmd,
  // Drive configuration
  input wire logic [4:0]  output_inversion_setting,
  input wire logic        width_basis_select,
  // Outputs
  input wire logic [1:0]  fast_out,
  input wire logic [2:0]  photo_out,
  input wire logic        param_combo_alarm
);
  logic [1:0] cnt_reg;
  logic       cfg_seen_reg;

  // Until the first setup command every entry is disabled, so outputs sit at the inversion level
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg      <= 2'h0;
      cfg_seen_reg <= 1'b0;
    end else begin
      cnt_reg      <= (cnt_reg == 2'h3) ? cnt_reg : cnt_reg + 2'h1;
      cfg_seen_reg <= cfg_seen_reg | config_cmd;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_rd_latency; rd_en |-> ##2 rd_valid; endproperty
  a_rd_latency: assert property (p_rd_latency) else $error("read answer late");
  property p_rd_cause; rd_valid |-> $past(rd_en, 2); endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("read answer without request");
  property p_rd_pulse; rd_valid && !$past(rd_en) |=> !rd_valid; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read valid too long");
  property p_rd_hold; !rd_valid |-> $stable(rd_data); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_no_cfg_idle;
    !cfg_seen_reg && cnt_reg == 2'h3 |->
      fast_out == output_inversion_setting[1:0] && photo_out == output_inversion_setting[4:2];
  endproperty
  a_no_cfg_idle: assert property (p_no_cfg_idle) else $error("output active before setup");
  property p_alarm_sticky; param_combo_alarm |=> param_combo_alarm; endproperty
  a_alarm_sticky: assert property (p_alarm_sticky) else $error("alarm cleared");
  property p_alarm_basis; $rose(param_combo_alarm) |-> width_basis_select && cfg_seen_reg; endproperty
  a_alarm_basis: assert property (p_alarm_basis) else $error("alarm without distance basis");
  property p_reset_quiet; !$past(resetn) |-> !param_combo_alarm && !rd_valid; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("output set out of reset");
endmodule

bind ppt_trigger ppt_trigger_assertions u_chk (.clk, .resetn, .rd_en, .rd_valid, .rd_data, .config_cmd,
  .output_inversion_setting, .width_basis_select, .fast_out, .photo_out, .param_combo_alarm);

// ---- dv/ppt_host_model.sv ----
// Host controller model: table writes, readback and setup commands
`timescale 1ns/1ps
`include "ppt_defines.svh"
module ppt_host_model (
  // Clock
  input  wire logic        clk,
  // Table access
  output logic             wr_en,
  output logic [5:0]       wr_entry,
  output logic [2:0]       wr_field,
  output logic [31:0]      wr_data,
  output logic             rd_en,
  output logic [5:0]       rd_entry,
  output logic [2:0]       rd_field,
  input  wire logic        rd_valid,
  input  wire logic [31:0] rd_data,
  // Setup command
  output logic             config_cmd
);
  initial begin
    wr_en      = 1'b0;
    wr_entry   = 6'h00;
    wr_field   = 3'h0;
    wr_data    = 32'h0000_0000;
    rd_en      = 1'b0;
    rd_entry   = 6'h00;
    rd_field   = 3'h0;
    config_cmd = 1'b0;
  end

  task automatic wr(input logic [5:0] e, input logic [2:0] f, input logic [31:0] d);
    @(negedge clk);
    wr_en    = 1'b1;
    wr_entry = e;
    wr_field = f;
    wr_data  = d;
    @(negedge clk);
    wr_en   = 1'b0;
    // Released data shows a fresh pattern so a stale word is never mistaken for the last one
    wr_data = ~d;
  endtask

  task automatic wr_fn(input logic [5:0] e, input logic [3:0] sel, input logic [3:0] dir);
    wr(e, `PPT_FLD_FUNCTION, {20'h00000, dir, sel, 4'h0});
  endtask

  task automatic rd(input logic [5:0] e, input logic [2:0] f, output logic [31:0] d, output logic v);
    @(negedge clk);
    rd_en    = 1'b1;
    rd_entry = e;
    rd_field = f;
    @(negedge clk);
    rd_en = 1'b0;
    // Answer stands between the second and third rising edges after the request
    @(negedge clk);
    v = rd_valid;
    d = rd_data;
  endtask

  task automatic cfg();
    @(negedge clk);
    config_cmd = 1'b1;
    @(negedge clk);
    config_cmd = 1'b0;
  endtask
endmodule

// ---- dv/ppt_trigger_tb.sv ----
// Self-checking bench for the preset position trigger table
`timescale 1ns/1ps
`include "ppt_defines.svh"
module ppt_trigger_tb;
  logic        clk;
  logic        resetn;
  logic [31:0] position;
  logic        wr_en;
  logic [5:0]  wr_entry;
  logic [2:0]  wr_field;
  logic [31:0] wr_data;
  logic        rd_en;
  logic [5:0]  rd_entry;
  logic [2:0]  rd_field;
  logic        rd_valid;
  logic [31:0] rd_data;
  logic        config_cmd;
  logic [4:0]  output_inversion_setting;
  logic        width_basis_select;
  logic        rotational_mode;
  logic [31:0] rotational_limit_first;
  logic [31:0] rotational_limit_second;
  logic [1:0]  fast_out;
  logic [2:0]  photo_out;
  logic        param_combo_alarm;
  int          n_errors;
  int          checks;

  ppt_host_model u_host (.clk, .wr_en, .wr_entry, .wr_field, .wr_data, .rd_en, .rd_entry, .rd_field,
    .rd_valid, .rd_data, .config_cmd);
  ppt_trigger #(.N_ENTRIES(32)) u_dut (.clk, .resetn, .position, .wr_en, .wr_entry, .wr_field, .wr_data,
    .rd_en, .rd_entry, .rd_field, .rd_valid, .rd_data, .config_cmd, .output_inversion_setting,
    .width_basis_select, .rotational_mode, .rotational_limit_first, .rotational_limit_second,
    .fast_out, .photo_out, .param_combo_alarm);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] b1(input logic x);
    return {31'h0, x};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Moves the drive, waits for fast output one, then times how long it stays high
  task automatic move(input logic [31:0] p, output logic hit, output int w);
    @(negedge clk);
    position = p;
    hit = 1'b0;
    w = 0;
    for (int i = 0; i < 300 && !hit; i++) begin
      @(negedge clk);
      hit = fast_out[0];
    end
    while (hit && fast_out[0] && w < 2000) begin
      @(negedge clk);
      w++;
    end
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic        v;
    for (int f = 0; f < 5; f++) begin
      u_host.rd(6'h00, f[2:0], d, v);
      chk("fast field", 32'h0, d);
      u_host.rd(6'h3f, f[2:0], d, v);
      chk("photo field", 32'h0, d);
      chk("read valid", 32'h1, b1(v));
    end
  endtask

  task automatic t_readback();
    logic [31:0] vals [5];
    logic [31:0] d;
    logic        v;
    vals = '{32'h8000_0000, 32'h0000_0230, 32'h01f3_fc18, 32'hffff_ffff, 32'h7fff_ffff};
    for (int f = 0; f < 5; f++) begin
      u_host.wr(6'h05, f[2:0], vals[f]);
      u_host.rd(6'h05, f[2:0], d, v);
      chk("readback", vals[f], d);
    end
    u_host.wr(6'h05, `PPT_FLD_FUNCTION, 32'h0000_0000);
  endtask

  task automatic t_codes();
    logic [1:0] ef;
    logic [2:0] ep;
    ef = 2'h0;
    ep = 3'h0;
    for (int c = 0; c <= 10; c++) begin
      u_host.wr_fn(6'h00, c[3:0], `PPT_DIR_FWD);
      u_host.wr_fn(6'h20, c[3:0], `PPT_DIR_FWD);
      repeat (3) @(negedge clk);
      chk("fast before setup", {30'h0, ef}, {30'h0, fast_out});
      chk("photo before setup", {29'h0, ep}, {29'h0, photo_out});
      u_host.cfg();
      repeat (3) @(negedge clk);
      ef = {c == 4, c == 3};
      ep = {c == 8, c == 7, c == 6};
      chk("fast code", {30'h0, ef}, {30'h0, fast_out});
      chk("photo code", {29'h0, ep}, {29'h0, photo_out});
    end
  endtask

  task automatic t_polarity();
    u_host.wr_fn(6'h01, `PPT_FSEL_OUT2_INV, `PPT_DIR_FWD);
    u_host.wr_fn(6'h02, `PPT_FSEL_OUT2, `PPT_DIR_FWD);
    u_host.cfg();
    repeat (3) @(negedge clk);
    chk("lowest entry wins", 32'h2, {30'h0, fast_out});
    output_inversion_setting = 5'h1e;
    repeat (3) @(negedge clk);
    chk("global inversion", 32'h1c, {27'h0, photo_out, fast_out});
    output_inversion_setting = 5'h00;
    u_host.wr_fn(6'h01, 4'h0, `PPT_DIR_FWD);
    u_host.wr_fn(6'h02, 4'h0, `PPT_DIR_FWD);
    u_host.cfg();
  endtask

  task automatic t_time();
    logic hit;
    int   w;
    u_host.wr(6'h03, `PPT_FLD_TARGET, 32'h0000_03e8);
    u_host.wr(6'h03, `PPT_FLD_OFFSET, 32'h0000_0018);
    u_host.wr(6'h03, `PPT_FLD_TIME, 32'h0000_000a);
    u_host.wr_fn(6'h03, `PPT_FSEL_OUT1, `PPT_DIR_FWD);
    u_host.cfg();
    repeat (200) @(negedge clk);
    move(32'h0000_03ff, hit, w);
    chk("short of point", 32'h0, b1(hit));
    move(32'h0000_0400, hit, w);
    chk("forward fire", 32'h1, b1(hit));
    chk("time width", 32'h1, b1(w > 150 && w < 400));
    move(32'h0000_0800, hit, w);
    move(32'h0000_0000, hit, w);
    chk("reverse ignored", 32'h0, b1(hit));
    u_host.wr_fn(6'h03, `PPT_FSEL_OUT1, `PPT_DIR_REV);
    move(32'h0000_0800, hit, w);
    chk("forward ignored", 32'h0, b1(hit));
    move(32'h0000_0000, hit, w);
    chk("reverse fire", 32'h1, b1(hit));
    u_host.wr_fn(6'h03, `PPT_FSEL_OUT1, `PPT_DIR_BOTH);
    move(32'h0000_0800, hit, w);
    chk("both fire", 32'h1, b1(hit));
  endtask

  task automatic t_dist();
    logic hit;
    int   w;
    width_basis_select = 1'b1;
    u_host.wr(6'h03, `PPT_FLD_DISTANCE, 32'h0000_0064);
    move(32'h0000_0000, hit, w);
    move(32'h0000_0406, hit, w);
    chk("distance hold", 32'h1, b1(hit && w == 2000));
    move(32'h0000_04b0, hit, w);
    chk("distance release", 32'h1, b1(w < 300));
  endtask

  task automatic t_alarm();
    u_host.wr(6'h03, `PPT_FLD_DISTANCE, 32'h7fff_ffff);
    repeat (200) @(negedge clk);
    chk("alarm linear", 32'h0, b1(param_combo_alarm));
    // Width goes in range before the mode switch so no visit sees a stale width
    u_host.wr(6'h03, `PPT_FLD_DISTANCE, 32'h0000_01f4);
    rotational_limit_first = 32'h0000_0064;
    rotational_limit_second = 32'h0000_03e8;
    rotational_mode = 1'b1;
    repeat (200) @(negedge clk);
    chk("alarm rotary in range", 32'h0, b1(param_combo_alarm));
    u_host.wr(6'h03, `PPT_FLD_DISTANCE, 32'h0000_07d0);
    repeat (200) @(negedge clk);
    chk("alarm rotary out", 32'h1, b1(param_combo_alarm));
  endtask

  // Generous bound: the whole sequence needs well under a third of this
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    finish_test();
  end

  initial begin
    n_errors = 0;
    checks = 0;
    resetn = 1'b0;
    position = 32'h0000_0000;
    output_inversion_setting = 5'h00;
    width_basis_select = 1'b0;
    rotational_mode = 1'b0;
    rotational_limit_first = 32'h0000_0000;
    rotational_limit_second = 32'h0000_0000;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_readback();
    t_codes();
    t_polarity();
    t_time();
    t_dist();
    t_alarm();
    finish_test();
  end
endmodule
